// ===== rtl/eq_adapt.sv
`timescale 1ns/100ps
module eq_adapt
  import eq_dbg_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_lock,
  input wire logic i_restart,
  input wire logic i_first_zero,
  input wire logic i_floor_en,
  input wire logic [3:0] i_floor,
  input wire logic [3:0] i_limit,
  input wire logic i_bypass,
  input wire logic [5:0] i_manual,
  input wire logic i_lock_waits,
  input wire wait_cnt_t i_wait_cycles,
  output logic [5:0] o_eq_setting,
  output logic o_rx_lock
);
  adapt_st_t s_r;
  adapt_st_t s_nxt;
  logic [3:0] start;
  logic timeout;

  always_comb begin
    start = i_floor_en ? i_floor : 4'h0;
    if (start > i_limit) begin
      start = i_limit;
    end
    timeout = (s_r.cnt >= i_wait_cycles - 23'h1);
    s_nxt = s_r;
    case (s_r.state)
      ST_IDLE: begin
        s_nxt.state = ST_SEARCH;
        s_nxt.idx = start;
        s_nxt.cnt = '0;
      end
      ST_SEARCH: begin
        if (i_lock) begin
          s_nxt.first_done = 1'b1;
          s_nxt.cnt = '0;
          if (i_first_zero && !s_r.first_done) begin
            s_nxt.idx = 4'h0;
          end else begin
            s_nxt.state = ST_LOCKED;
          end
        end else if (timeout) begin
          s_nxt.cnt = '0;
          s_nxt.idx = (s_r.idx >= i_limit) ? start : 4'(s_r.idx + 4'h1);
        end else begin
          s_nxt.cnt = 23'(s_r.cnt + 23'h1);
        end
      end
      ST_LOCKED: begin
        if (!i_lock) begin
          s_nxt.state = ST_SEARCH;
          s_nxt.cnt = '0;
        end
      end
      default: s_nxt.state = ST_IDLE;
    endcase
    if (i_restart) begin
      s_nxt.state = ST_SEARCH;
      s_nxt.idx = start;
      s_nxt.cnt = '0;
    end
    // a limit lowered by software pulls a running search down at once
    if (s_nxt.idx > i_limit) begin
      s_nxt.idx = i_limit;
    end
    s_nxt.setting = i_bypass ? i_manual : {2'h0, s_nxt.idx};
    s_nxt.rx_lock = i_lock & (!i_lock_waits | i_bypass | (s_nxt.state == ST_LOCKED));
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s_r <= '{state: ST_IDLE, idx: 4'h0, cnt: 23'h0, first_done: 1'b0, setting: 6'h00, rx_lock: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_eq_setting = s_r.setting;
  assign o_rx_lock = s_r.rx_lock;

  step_one_a: assert property (@(posedge i_clk) disable iff (i_rst)
    s_r.state == ST_SEARCH && !i_lock && !i_restart && timeout && s_r.idx < i_limit && $stable(i_limit)
    |=> s_r.idx == 4'($past(s_r.idx) + 4'h1))
    else $error("search did not step by one");
  wrap_start_a: assert property (@(posedge i_clk) disable iff (i_rst)
    s_r.state == ST_SEARCH && !i_lock && !i_restart && timeout && s_r.idx >= i_limit |=> s_r.idx == $past(start))
    else $error("search did not wrap to start");
  floor_start_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_restart && i_floor_en && i_floor <= i_limit |=> s_r.idx == $past(i_floor))
    else $error("restart ignored the floor");
  upper_limit_a: assert property (@(posedge i_clk) disable iff (i_rst)
    1'b1 |-> s_r.idx <= $past(i_limit))
    else $error("setting above the upper limit");
  first_zero_a: assert property (@(posedge i_clk) disable iff (i_rst)
    s_r.state == ST_SEARCH && i_lock && i_first_zero && !s_r.first_done && !i_restart
    |=> s_r.idx == 4'h0 && s_r.state == ST_SEARCH)
    else $error("first lock did not restart at zero");
  manual_set_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_bypass |=> o_eq_setting == $past(i_manual))
    else $error("manual setting not applied");
  lock_gate_a: assert property (@(posedge i_clk) disable iff (i_rst)
    o_rx_lock && $past(i_lock_waits) && !$past(i_bypass) |-> $past(i_lock) && s_r.state == ST_LOCKED)
    else $error("lock reported before adaptation ended");
  reset_zero_a: assert property (@(posedge i_clk) disable iff (i_rst)
    $past(i_rst) |-> o_eq_setting == 6'h00)
    else $error("state not zero after reset");
  step_cov: cover property (@(posedge i_clk) disable iff (i_rst)
    s_r.state == ST_SEARCH && timeout && !i_lock);
  first_cov: cover property (@(posedge i_clk) disable iff (i_rst)
    s_r.state == ST_SEARCH && i_lock && i_first_zero && !s_r.first_done);
endmodule

// ===== rtl/eq_dbg_defs.svh
`ifndef EQ_DBG_DEFS_SVH
`define EQ_DBG_DEFS_SVH

// ------------------------------------------------------------
// register offsets and reset values
// ------------------------------------------------------------
`define OFS_SPARE_BF 8'hbf
`define OFS_SPARE_C0 8'hc0
`define OFS_SPARE_CF 8'hcf
`define OFS_DEBUG_CTL 8'hd0
`define OFS_SPARE_D1 8'hd1
`define OFS_ADAPT_CTL 8'hd2
`define OFS_EQ_STATE 8'hd3
`define OFS_MANUAL 8'hd4
`define OFS_LIMITS 8'hd5
`define RST_DEBUG_CTL 2'h0
`define RST_SPARE_D1 8'h43
`define RST_ADAPT_CTL 8'h94
`define RST_MANUAL 8'h60
`define RST_LIMITS 8'hf2

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define SEL_RD_LO 4
`define DBG_SELFTEST 5
`define DBG_CONT 1
`define DBG_ONCE 0
`define CTL_WAIT_LO 5
`define CTL_FIRST 4
`define CTL_RESTART 3
`define CTL_FLOOR_EN 2
`define MAN_UPPER_LO 5
`define MAN_LOCKW 4
`define MAN_LOWER_LO 1
`define MAN_BYPASS 0
`define LIM_MAX_LO 4

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define CLK_PERIOD_NS 4
`define T_WAIT0_NS 164000
`define T_WAIT1_NS 328000
`define T_WAIT2_NS 655000
`define T_WAIT3_NS 1310000
`define T_WAIT4_NS 2620000
`define T_WAIT5_NS 5240000
`define T_WAIT6_NS 10500000
`define T_WAIT7_NS 21000000
`define NS_TO_CYC(t) (((t) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ===== rtl/eq_dbg_pkg.sv
package eq_dbg_pkg;
  typedef logic [22:0] wait_cnt_t;
  typedef enum logic [1:0] {ST_IDLE, ST_SEARCH, ST_LOCKED} adapt_state_t;
  typedef struct packed {
    adapt_state_t state;
    logic [3:0] idx;
    wait_cnt_t cnt;
    logic first_done;
    logic [5:0] setting;
    logic rx_lock;
  } adapt_st_t;
  typedef struct packed {
    logic [1:0] dbg;
    logic [7:0] ctl;
    logic [7:0] man;
    logic [7:0] lim;
    logic corrupt;
  } port_st_t;
  typedef struct packed {
    logic [3:0] lock_s1;
    logic [3:0] lock_s2;
    logic [3:0] bist_s1;
    logic [3:0] bist_s2;
    logic [7:0] rdata;
  } top_st_t;
endpackage

// ===== rtl/rx_port_equalizer_debug_regs.sv
`timescale 1ns/100ps
`include "eq_dbg_defs.svh"
module rx_port_equalizer_debug_regs
  import eq_dbg_pkg::*;
#(
  parameter int unsigned P_WAIT0 = `NS_TO_CYC(`T_WAIT0_NS),
  parameter int unsigned P_WAIT1 = `NS_TO_CYC(`T_WAIT1_NS),
  parameter int unsigned P_WAIT2 = `NS_TO_CYC(`T_WAIT2_NS),
  parameter int unsigned P_WAIT3 = `NS_TO_CYC(`T_WAIT3_NS),
  parameter int unsigned P_WAIT4 = `NS_TO_CYC(`T_WAIT4_NS),
  parameter int unsigned P_WAIT5 = `NS_TO_CYC(`T_WAIT5_NS),
  parameter int unsigned P_WAIT6 = `NS_TO_CYC(`T_WAIT6_NS),
  parameter int unsigned P_WAIT7 = `NS_TO_CYC(`T_WAIT7_NS)
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_page_sel,
  input wire logic [7:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic [7:0] i_reg_wdata,
  input wire logic i_reg_rd,
  output logic [7:0] o_reg_rdata,
  input wire logic [3:0] i_lock_det,
  input wire logic [3:0] i_far_selftest,
  input wire logic [3:0] i_bc_frame,
  output logic [3:0] o_bc_corrupt,
  output logic [23:0] o_eq_setting,
  output logic [3:0] o_rx_lock
);

  // ------------------------------------------------------------
  // per-port wiring
  // ------------------------------------------------------------
  logic [1:0] dbg_w [4];
  logic [7:0] ctl_w [4];
  logic [7:0] man_w [4];
  logic [7:0] lim_w [4];
  logic [5:0] set_w [4];
  logic [3:0] wr_port;
  logic [1:0] rd_port;
  top_st_t s_r;
  top_st_t s_nxt;

  assign rd_port = i_page_sel[`SEL_RD_LO +: 2];
  assign wr_port = {4{i_reg_wr}} & i_page_sel[3:0];

  // ------------------------------------------------------------
  // wait time lookup
  // ------------------------------------------------------------
  // every code maps to its own parameter so a bench can shrink all eight
  function automatic wait_cnt_t wait_lookup(input logic [2:0] code);
    case (code)
      3'h0: wait_lookup = wait_cnt_t'(P_WAIT0);
      3'h1: wait_lookup = wait_cnt_t'(P_WAIT1);
      3'h2: wait_lookup = wait_cnt_t'(P_WAIT2);
      3'h3: wait_lookup = wait_cnt_t'(P_WAIT3);
      3'h4: wait_lookup = wait_cnt_t'(P_WAIT4);
      3'h5: wait_lookup = wait_cnt_t'(P_WAIT5);
      3'h6: wait_lookup = wait_cnt_t'(P_WAIT6);
      default: wait_lookup = wait_cnt_t'(P_WAIT7);
    endcase
  endfunction

  // ------------------------------------------------------------
  // receive ports
  // ------------------------------------------------------------
  for (genvar p = 0; p < 4; p++) begin : g_port
    // each port owns its registers, engine and timer
    rx_port_regs u_regs (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_wr(wr_port[p]),
      .i_addr(i_reg_addr),
      .i_wdata(i_reg_wdata),
      .i_frame(i_bc_frame[p]),
      .o_dbg(dbg_w[p]),
      .o_ctl(ctl_w[p]),
      .o_man(man_w[p]),
      .o_lim(lim_w[p]),
      .o_corrupt(o_bc_corrupt[p])
    );

    eq_adapt u_adapt (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_lock(s_r.lock_s2[p]),
      .i_restart(ctl_w[p][`CTL_RESTART]),
      .i_first_zero(ctl_w[p][`CTL_FIRST]),
      .i_floor_en(ctl_w[p][`CTL_FLOOR_EN]),
      .i_floor(lim_w[p][3:0]),
      .i_limit(lim_w[p][`LIM_MAX_LO +: 4]),
      .i_bypass(man_w[p][`MAN_BYPASS]),
      .i_manual({man_w[p][`MAN_UPPER_LO +: 3], man_w[p][`MAN_LOWER_LO +: 3]}),
      .i_lock_waits(man_w[p][`MAN_LOCKW]),
      .i_wait_cycles(wait_lookup(ctl_w[p][`CTL_WAIT_LO +: 3])),
      .o_eq_setting(set_w[p]),
      .o_rx_lock(o_rx_lock[p])
    );

    assign o_eq_setting[6*p +: 6] = set_w[p];
  end

  // ------------------------------------------------------------
  // synchronisers and read path
  // ------------------------------------------------------------
  // lock and far self-test come from the analog side, so two stages each
  always_comb begin
    s_nxt = s_r;
    s_nxt.lock_s1 = i_lock_det;
    s_nxt.lock_s2 = s_r.lock_s1;
    s_nxt.bist_s1 = i_far_selftest;
    s_nxt.bist_s2 = s_r.bist_s1;
    if (i_reg_rd) begin
      case (i_reg_addr)
        `OFS_DEBUG_CTL: s_nxt.rdata = {2'h0, s_r.bist_s2[rd_port], 3'h0, dbg_w[rd_port]};
        `OFS_SPARE_D1: s_nxt.rdata = `RST_SPARE_D1;
        `OFS_ADAPT_CTL: s_nxt.rdata = ctl_w[rd_port];
        `OFS_EQ_STATE: s_nxt.rdata = {2'h0, set_w[rd_port]};
        `OFS_MANUAL: s_nxt.rdata = man_w[rd_port];
        `OFS_LIMITS: s_nxt.rdata = lim_w[rd_port];
        default: s_nxt.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s_r <= '{lock_s1: 4'h0, lock_s2: 4'h0, bist_s1: 4'h0, bist_s2: 4'h0, rdata: 8'h00};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_reg_rdata = s_r.rdata;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  rd_page_sel_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_reg_rd && i_reg_addr == `OFS_LIMITS && !i_reg_wr && rd_port == 2'h2
    |=> o_reg_rdata == $past(lim_w[2]))
    else $error("read did not follow read select");
  rd_state_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_reg_rd && i_reg_addr == `OFS_EQ_STATE && rd_port == 2'h1
    |=> o_reg_rdata == {2'h0, $past(set_w[1])})
    else $error("state read does not match setting");
  wr_update_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_reg_wr && i_reg_addr == `OFS_MANUAL && i_page_sel[0] |=> man_w[0] == $past(i_reg_wdata))
    else $error("enabled port not written");
  wr_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_reg_wr && i_reg_addr == `OFS_LIMITS && !i_page_sel[3] |=> $stable(lim_w[3]))
    else $error("disabled port was written");
  selftest_rd_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_reg_rd && i_reg_addr == `OFS_DEBUG_CTL && rd_port == 2'h3
    |=> o_reg_rdata[`DBG_SELFTEST] == $past(s_r.bist_s2[3]))
    else $error("far self test bit wrong");
  spare_rd_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_reg_rd && i_reg_addr >= `OFS_SPARE_C0 && i_reg_addr <= `OFS_SPARE_CF |=> o_reg_rdata == 8'h00)
    else $error("spare range not zero");
  multi_wr_cov: cover property (@(posedge i_clk) disable iff (i_rst)
    i_reg_wr && i_reg_addr == `OFS_ADAPT_CTL && i_page_sel[3:0] == 4'hf);
  bypass_cov: cover property (@(posedge i_clk) disable iff (i_rst)
    man_w[0][`MAN_BYPASS] && o_rx_lock[0]);
endmodule

// ===== rtl/rx_port_regs.sv
`timescale 1ns/100ps
`include "eq_dbg_defs.svh"
module rx_port_regs
  import eq_dbg_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_wr,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_frame,
  output logic [1:0] o_dbg,
  output logic [7:0] o_ctl,
  output logic [7:0] o_man,
  output logic [7:0] o_lim,
  output logic o_corrupt
);
  port_st_t s_r;
  port_st_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.corrupt = i_frame & (s_r.dbg[`DBG_CONT] | s_r.dbg[`DBG_ONCE]);
    s_nxt.ctl[`CTL_RESTART] = 1'b0;
    if (i_frame) begin
      s_nxt.dbg[`DBG_ONCE] = 1'b0;
    end
    // the write comes last so a new one-shot request beats the frame's clear
    if (i_wr) begin
      case (i_addr)
        `OFS_DEBUG_CTL: s_nxt.dbg = i_wdata[1:0];
        `OFS_ADAPT_CTL: s_nxt.ctl = {i_wdata[7:2], 2'h0};
        `OFS_MANUAL: s_nxt.man = i_wdata;
        `OFS_LIMITS: s_nxt.lim = i_wdata;
        default: s_nxt.dbg = s_r.dbg;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      s_r <= '{dbg: `RST_DEBUG_CTL, ctl: `RST_ADAPT_CTL, man: `RST_MANUAL, lim: `RST_LIMITS, corrupt: 1'b0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_dbg = s_r.dbg;
  assign o_ctl = s_r.ctl;
  assign o_man = s_r.man;
  assign o_lim = s_r.lim;
  assign o_corrupt = s_r.corrupt;

  cont_inject_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_frame && s_r.dbg[`DBG_CONT] |=> o_corrupt)
    else $error("continuous inject missed a frame");
  once_clear_a: assert property (@(posedge i_clk) disable iff (i_rst)
    s_r.dbg[`DBG_ONCE] && i_frame && !i_wr |=> o_corrupt && !s_r.dbg[`DBG_ONCE])
    else $error("one-shot inject did not fire and clear");
  restart_clear_a: assert property (@(posedge i_clk) disable iff (i_rst)
    s_r.ctl[`CTL_RESTART] |=> !s_r.ctl[`CTL_RESTART] || $past(i_wr))
    else $error("restart bit did not self clear");
  once_cov: cover property (@(posedge i_clk) disable iff (i_rst)
    s_r.dbg[`DBG_ONCE] ##1 i_frame ##1 o_corrupt);
endmodule

// ===== sim/tb.sv
`timescale 1ns/100ps
module tb;
  import eq_dbg_pkg::*;
  logic i_clk, i_rst, i_reg_wr, i_reg_rd;
  logic [7:0] i_page_sel, i_reg_addr, i_reg_wdata, o_reg_rdata;
  logic [3:0] i_lock_det, i_far_selftest, i_bc_frame, o_bc_corrupt, o_rx_lock;
  logic [23:0] o_eq_setting;
  int n_fail, tests_run;

  // codes 0..4 shortened so that code k waits 20 + 10k cycles; codes 5..7 keep their full length
  rx_port_equalizer_debug_regs #(.P_WAIT0(20), .P_WAIT1(30), .P_WAIT2(40), .P_WAIT3(50),
    .P_WAIT4(60)) i_rx_port_equalizer_debug_regs (
    .i_clk(i_clk), .i_rst(i_rst), .i_page_sel(i_page_sel), .i_reg_addr(i_reg_addr),
    .i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata), .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata),
    .i_lock_det(i_lock_det), .i_far_selftest(i_far_selftest), .i_bc_frame(i_bc_frame),
    .o_bc_corrupt(o_bc_corrupt), .o_eq_setting(o_eq_setting), .o_rx_lock(o_rx_lock));

  initial begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic timeout();
    n_fail++;
    stop_test();
  endtask

  task automatic wr(input logic [7:0] p, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_page_sel <= p;
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_wr <= 1'b1;
    @(posedge i_clk);
    i_reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] p, input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk);
    i_page_sel <= p;
    i_reg_addr <= a;
    i_reg_rd <= 1'b1;
    @(posedge i_clk);
    i_reg_rd <= 1'b0;
    #1 d = o_reg_rdata;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  function automatic logic [5:0] eqp(input int p);
    return o_eq_setting[6*p +: 6];
  endfunction

  // counts edges until port p's setting moves; a hang ends the run
  task automatic wait_change(input int p, output int n);
    logic [5:0] v;
    v = eqp(p);
    n = 0;
    while (eqp(p) === v) begin
      @(posedge i_clk);
      #1 n++;
      if (n > 400) timeout();
    end
  endtask

  task automatic wait_lock(input int p);
    int i;
    for (i = 0; i < 20 && o_rx_lock[p] !== 1'b1; i++) cyc(1);
    if (i == 20) timeout();
  endtask

  task automatic frames(input int p, input int n, input logic [3:0] exp);
    @(posedge i_clk);
    i_bc_frame <= 4'h1 << p;
    for (int i = 0; i < n; i++) begin
      @(posedge i_clk);
      if (i == n - 1) i_bc_frame <= 4'h0;
      #1 check(o_bc_corrupt, exp);
    end
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset_vals();
    logic [7:0] d;
    logic [7:0] adr [9] = '{8'hd0, 8'hd1, 8'hd2, 8'hd4, 8'hd5, 8'hbf, 8'hc0, 8'hcf, 8'h10};
    logic [7:0] exp [9] = '{8'h00, 8'h43, 8'h94, 8'h60, 8'hf2, 8'h00, 8'h00, 8'h00, 8'h00};
    rd(8'h00, 8'hd3, d);
    check(d, 8'h02);
    for (int p = 0; p < 4; p++) begin
      for (int i = 0; i < 9; i++) begin
        rd(8'(p << 4), adr[i], d);
        check(d, exp[i]);
      end
    end
  endtask

  task automatic t_paging();
    logic [7:0] d;
    wr(8'h05, 8'hd5, 8'h8a);
    for (int p = 0; p < 4; p++) begin
      rd(8'(p << 4), 8'hd5, d);
      check(d, (p % 2 == 0) ? 8'h8a : 8'hf2);
    end
    // no enable bit set: nothing may change
    wr(8'h00, 8'hd5, 8'h11);
    rd(8'h00, 8'hd5, d);
    check(d, 8'h8a);
    wr(8'h0f, 8'hd1, 8'h00);
    rd(8'h30, 8'hd1, d);
    check(d, 8'h43);
  endtask

  task automatic t_back_channel();
    logic [7:0] d;
    wr(8'h12, 8'hd0, 8'h21);
    frames(1, 1, 4'h2);
    frames(1, 1, 4'h0);
    rd(8'h12, 8'hd0, d);
    check(d, 8'h00);
    wr(8'h12, 8'hd0, 8'h02);
    rd(8'h12, 8'hd0, d);
    check(d, 8'h02);
    frames(1, 3, 4'h2);
    wr(8'h12, 8'hd0, 8'h00);
    frames(1, 1, 4'h0);
  endtask

  task automatic t_selftest();
    logic [7:0] d;
    @(posedge i_clk);
    i_far_selftest <= 4'h4;
    cyc(4);
    rd(8'h20, 8'hd0, d);
    check(d, 8'h20);
    rd(8'h10, 8'hd0, d);
    check(d, 8'h00);
    @(posedge i_clk);
    i_far_selftest <= 4'h0;
  endtask

  task automatic t_bypass();
    logic [7:0] d;
    wr(8'h01, 8'hd4, 8'ha7);
    cyc(2);
    check(eqp(0), 6'h2b);
    rd(8'h00, 8'hd3, d);
    check(d, 8'h2b);
    rd(8'h00, 8'hd4, d);
    check(d, 8'ha7);
  endtask

  task automatic t_locks();
    // port 1 has searched since reset; its first lock must pull the setting to zero
    // port 0 is bypassed: it locks with port 1 but keeps its manual setting
    @(posedge i_clk);
    i_lock_det[1:0] <= 2'h3;
    wait_lock(1);
    check(eqp(1), 6'h00);
    check(eqp(0), 6'h2b);
    check(o_rx_lock, 4'h3);
    // port 2: floor above limit clamps the start, no zero restart on first lock
    wr(8'h04, 8'hd4, 8'h70);
    wr(8'h04, 8'hd2, 8'h8c);
    cyc(3);
    check(eqp(2), 6'h08);
    @(posedge i_clk);
    i_lock_det[2] <= 1'b1;
    wait_lock(2);
    check(eqp(2), 6'h08);
  endtask

  task automatic t_wrap();
    int n;
    logic [5:0] seq [4] = '{6'h1, 6'h2, 6'h3, 6'h0};
    wr(8'h08, 8'hd5, 8'h30);
    wr(8'h08, 8'hd2, 8'h18);
    cyc(3);
    check(eqp(3), 6'h00);
    for (int i = 0; i < 4; i++) begin
      wait_change(3, n);
      check(eqp(3), seq[i]);
    end
  endtask

  task automatic t_wait_codes();
    int n, base;
    logic [7:0] d;
    wr(8'h08, 8'hd5, 8'hf0);
    for (int k = 0; k < 8; k++) begin
      wr(8'h08, 8'hd2, 8'((k << 5) | 8'h18));
      rd(8'h38, 8'hd2, d);
      check(d, 8'((k << 5) | 8'h10));
      if (k > 4) begin
        // full-length codes wait far beyond this window, so the restart value must hold
        cyc(300);
        check(eqp(3), 6'h00);
      end else begin
        wait_change(3, n);
        wait_change(3, n);
        wait_change(3, n);
        if (k == 0) begin
          base = n;
          check(n >= 20 && n <= 22, 1'b1);
        end else begin
          check(n - base, 10 * k);
        end
      end
    end
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    n_fail = 0;
    tests_run = 0;
    i_rst = 1'b1;
    i_reg_wr = 1'b0;
    i_reg_rd = 1'b0;
    i_page_sel = 8'h00;
    i_reg_addr = 8'h00;
    i_reg_wdata = 8'h00;
    i_lock_det = 4'h0;
    i_far_selftest = 4'h0;
    i_bc_frame = 4'h0;
    cyc(10);
    check(o_eq_setting, 24'h000000);
    check({o_reg_rdata, o_rx_lock, o_bc_corrupt}, 16'h0000);
    repeat (10) @(posedge i_clk);
    i_rst <= 1'b0;
    t_reset_vals();
    t_paging();
    t_back_channel();
    t_selftest();
    t_bypass();
    t_locks();
    t_wrap();
    t_wait_codes();
    stop_test();
  end
endmodule
